// file: rtl/lbrp_port.sv
// Local bus register port: 32 word registers, pass-thru address path,
// buffered host clock and reset, interrupt pins and output float.
// Assumes the local party keeps address, lanes and data stable while a
// strobe is active, and that host-side inputs are levels.
`timescale 1ns/1ps

module lbrp_port
  import lbrp_pkg::*;
(
  // Local side clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Host side pass-through
  input  wire logic        host_clk_i,
  input  wire logic        host_rst_n_i,
  input  wire logic        sw_reset_cmd_i,
  output logic             buffered_host_clock_o,
  output logic             buffered_host_reset_n_o,
  // Register access pins
  input  wire logic        select_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [4:0]  word_addr_i,
  input  wire logic [3:0]  byte_lane_enable_n_i,
  input  wire logic        bus_width_select_i,
  input  wire logic [31:0] dq_i,
  output logic      [31:0] dq_o,
  output logic      [3:0]  dq_oe_n_o,
  // Pass-thru path
  input  wire logic        passthru_addr_strobe_n_i,
  input  wire logic [31:0] passthru_addr_i,
  input  wire logic [1:0]  passthru_region_size_i,
  output logic      [31:0] passthru_data_o,
  output logic             passthru_data_wr_o,
  // Interrupts
  input  wire logic        internal_event_i,
  output logic             local_irq_n_o,
  input  wire logic        local_to_host_int_n_i,
  input  wire logic        host_int_enable_i,
  output logic             inta_n_o,
  output logic             inta_oe_n_o,
  // Float control
  input  wire logic        float_outputs_n_i,
  output logic             pin_oe_n_o
);

  logic [31:0]     regs [32];
  logic [SY_N-1:0] s1;
  logic [SY_N-1:0] s2;
  logic [SY_N-1:0] s3;
  logic [SY_N-1:0] st;
  logic            wr_seen;
  logic [31:0]     dq_q;
  logic [3:0]      drv_n;
  logic            irq_q;
  logic            inta_drive;
  logic            wr_pulse;

  wire logic [SY_N-1:0] pins = {float_outputs_n_i, local_to_host_int_n_i,
                                passthru_addr_strobe_n_i,
                                bus_width_select_i, wr_n_i, rd_n_i,
                                select_n_i};
  wire logic [SY_N-1:0] agree = ~(s2 ^ s3);

  wire logic acc_rd = ~st[SY_SEL] & ~st[SY_RD];
  wire logic acc_wr = ~st[SY_SEL] & ~st[SY_WR];
  wire logic wr_go  = acc_wr & ~wr_seen;
  wire logic pt_on  = ~st[SY_PTAS];
  wire logic flt_on = ~st[SY_FLT];
  wire logic is_pt  = word_addr_i == PT_DATA_IDX;
  wire logic pt16   = passthru_region_size_i == REGION_W16;
  wire logic mode16 = is_pt ? pt16 : st[SY_WIDTH];
  wire logic hi     = byte_lane_enable_n_i[3];
  wire logic [1:0] lo_en = ~byte_lane_enable_n_i[1:0];

  wire logic [3:0] reg_en = !mode16 ? ~byte_lane_enable_n_i :
                            hi ? {lo_en, 2'h0} : {2'h0, lo_en};
  wire logic [3:0] pin_en = mode16 ? {2'h0, lo_en} :
                                     ~byte_lane_enable_n_i;
  wire logic [31:0] wdat  = mode16 ? {dq_i[15:0], dq_i[15:0]} : dq_i;
  wire logic [31:0] rword = regs[word_addr_i];
  wire logic [31:0] rdat  = !mode16 ? rword :
                            {16'h0, hi ? rword[31:16] : rword[15:0]};
  wire logic [31:0] bmask = {{8{reg_en[3]}}, {8{reg_en[2]}},
                             {8{reg_en[1]}}, {8{reg_en[0]}}};
  wire logic [31:0] next_word = (rword & ~bmask) | (wdat & bmask);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= SYNC_RESET;
      s2 <= SYNC_RESET;
      s3 <= SYNC_RESET;
      st <= SYNC_RESET;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      st <= (st & ~agree) | (s3 & agree);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_seen  <= 1'b0;
      wr_pulse <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= REG_RESET;
      end
    end else begin
      wr_seen  <= acc_wr;
      wr_pulse <= wr_go & is_pt;
      if (wr_go) begin
        regs[word_addr_i] <= next_word;
      end
    end
  end

  // Read data is registered, so lanes turn on one cycle after decode
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_q  <= REG_RESET;
      drv_n <= LANES_OFF;
    end else if (pt_on) begin
      dq_q  <= passthru_addr_i;
      drv_n <= 4'h0;
    end else if (acc_rd) begin
      dq_q  <= rdat;
      drv_n <= ~pin_en;
    end else begin
      drv_n <= LANES_OFF;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q      <= 1'b1;
      inta_drive <= 1'b0;
    end else begin
      irq_q      <= ~internal_event_i;
      inta_drive <= ~st[SY_L2H] & host_int_enable_i;
    end
  end

  assign buffered_host_clock_o   = host_clk_i;
  assign buffered_host_reset_n_o = host_rst_n_i & ~sw_reset_cmd_i;
  assign dq_o                    = dq_q;
  assign passthru_data_o         = regs[PT_DATA_IDX];
  assign passthru_data_wr_o      = wr_pulse;
  assign local_irq_n_o           = irq_q;
  assign inta_n_o                = 1'b0;
  // float all drivers
  // Float passes the synchroniser, so it takes hold a few cycles late
  assign dq_oe_n_o   = drv_n | {4{flt_on}};
  assign inta_oe_n_o = ~inta_drive | flt_on;
  assign pin_oe_n_o  = flt_on;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  access_gate_a : assert property (
    (!acc_rd && !pt_on) |=> (drv_n == LANES_OFF))
    else $error("lanes driven without a read access");

  write_byte_a : assert property (
    (wr_go && !mode16 && !byte_lane_enable_n_i[0]) |=>
      (regs[$past(word_addr_i)][7:0] == $past(dq_i[7:0])))
    else $error("enabled byte not stored");

  write_once_a : assert property (
    wr_go |=> !wr_go)
    else $error("second store within one strobe");

  read_lanes_a : assert property (
    (acc_rd && !pt_on && !mode16) |=>
      (drv_n == $past(byte_lane_enable_n_i)))
    else $error("read lanes differ from enables");

  half_lanes_a : assert property (
    (acc_rd && !pt_on && mode16) |=> (drv_n[3:2] == 2'h3))
    else $error("upper lanes driven in 16-bit mode");

  half_data_a : assert property (
    (acc_rd && !pt_on && mode16 && hi) |=>
      (dq_q[15:0] == $past(rword[31:16])))
    else $error("upper half not selected");

  pt_width_a : assert property (
    (acc_rd && !pt_on && is_pt && !pt16 && st[SY_WIDTH]) |=>
      (drv_n == $past(byte_lane_enable_n_i)))
    else $error("pass-thru port width taken from width pin");

  pt_addr_a : assert property (
    pt_on |=> (drv_n == 4'h0) && (dq_q == $past(passthru_addr_i)))
    else $error("pass-thru address not presented");

  sw_reset_a : assert property (
    sw_reset_cmd_i |-> !buffered_host_reset_n_o)
    else $error("software reset not buffered out");

  host_int_a : assert property (
    (!local_to_host_int_n_i && host_int_enable_i)[*5] |=>
      !inta_oe_n_o || flt_on)
    else $error("host interrupt not driven");

  local_irq_a : assert property (
    internal_event_i |=> !local_irq_n_o)
    else $error("local irq not raised");

  float_a : assert property (
    flt_on |-> (dq_oe_n_o == LANES_OFF) && inta_oe_n_o && pin_oe_n_o)
    else $error("output driven while floated");

  read_data_a : assert property (
    (acc_rd && !pt_on && !mode16) |=> (dq_q == $past(rword)))
    else $error("read word not presented");

  write_keep_a : assert property (
    (wr_go && !mode16 && byte_lane_enable_n_i[0]) |=>
      (regs[$past(word_addr_i)][7:0] == $past(rword[7:0])))
    else $error("disabled byte overwritten");

  write_low_a : assert property (
    (wr_go && mode16 && !hi && !byte_lane_enable_n_i[0]) |=>
      (regs[$past(word_addr_i)][7:0] == $past(dq_i[7:0])))
    else $error("lower half not written");

  write_high_a : assert property (
    (wr_go && mode16 && hi && !byte_lane_enable_n_i[0]) |=>
      (regs[$past(word_addr_i)][23:16] == $past(dq_i[7:0])))
    else $error("upper half not written");

  pt_pulse_a : assert property (
    (wr_go && is_pt) |=> passthru_data_wr_o ##1 !passthru_data_wr_o)
    else $error("pass-thru store pulse wrong");

  no_select_a : assert property (
    st[SY_SEL] |=> $stable(passthru_data_o))
    else $error("pass-thru word changed without select");

  inta_release_a : assert property (
    local_to_host_int_n_i[*5] |=> inta_oe_n_o)
    else $error("host interrupt held after release");

  irq_clear_a : assert property (
    !internal_event_i |=> local_irq_n_o)
    else $error("local irq held without event");

  float_sync_a : assert property (
    (!float_outputs_n_i)[*5] |->
      pin_oe_n_o && inta_oe_n_o && (dq_oe_n_o == LANES_OFF))
    else $error("float pin not obeyed");

  cov_write_c : cover property (wr_go && is_pt);
  cov_read16_c : cover property (acc_rd && mode16 ##1 !acc_rd);
  cov_ptaddr_c : cover property (pt_on ##1 !pt_on);
  cov_float_c : cover property (flt_on && inta_drive);

endmodule : lbrp_port

// file: rtl/lbrp_pkg.sv
// Constants for the local bus register port.
// Assumes one local clock; strobe, width, host-interrupt and float pins are synchronised inside the port.
package lbrp_pkg;

  // Word index of the pass-thru data port (byte offset 2Ch)
  localparam logic [6:0] PT_DATA_OFFSET = 7'h2c;
  localparam logic [4:0] PT_DATA_IDX    = PT_DATA_OFFSET[6:2];

  // Region-size code of the matching base address register
  localparam logic [1:0] REGION_W32 = 2'h0;
  localparam logic [1:0] REGION_W16 = 2'h2;

  // Bit positions in the pin synchroniser
  localparam int SY_SEL   = 0;
  localparam int SY_RD    = 1;
  localparam int SY_WR    = 2;
  localparam int SY_WIDTH = 3;
  localparam int SY_PTAS  = 4;
  localparam int SY_L2H   = 5;
  localparam int SY_FLT   = 6;
  localparam int SY_N     = 7;

  // Values after reset
  localparam logic [SY_N-1:0] SYNC_RESET = 7'h77;
  localparam logic [31:0]     REG_RESET  = 32'h0;
  localparam logic [3:0]      LANES_OFF  = 4'hf;

endpackage : lbrp_pkg

// file: test/lbrp_local_model.sv
// Local add-on logic model: drives register accesses on the port pins.
// Assumes the bench clock; pins change 1 ns after a rising edge.
`timescale 1ns/1ps
module lbrp_local_model (
  // Clock and read-back of {lane enables, data}
  input  wire logic        clk_i,
  input  wire logic [35:0] rdata_i,
  // Register access pins
  output logic             select_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [4:0]       addr_o,
  output logic [3:0]       lanes_o,
  output logic [31:0]      dq_o
);
  initial begin
    {select_n_o, rd_n_o, wr_n_o} = 3'h7;
    addr_o = 5'h0;
    lanes_o = 4'hf;
    dq_o = 32'h0;
  end

  task automatic access(input logic s, input logic w, input logic [4:0] a,
                        input logic [3:0] l, input logic [31:0] d,
                        output logic [35:0] q);
    @(posedge clk_i) #1;
    select_n_o = ~s;
    addr_o = a;
    lanes_o = l;
    dq_o = d;
    wr_n_o = ~w;
    rd_n_o = w;
    repeat (6) @(posedge clk_i);
    q = rdata_i;
    #1;
    {select_n_o, rd_n_o, wr_n_o} = 3'h7;
    // Released data lines never keep the old value
    dq_o = ~d;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : access
endmodule : lbrp_local_model

// file: test/lbrp_port_tb.sv
// Self-checking bench for the local bus register port.
// Assumes the port's pins are driven only by this bench and its model.
`timescale 1ns/1ps
module lbrp_port_tb;
  import lbrp_pkg::*;
  logic        clk, rst_b, hclk, hrst_n, sw_cmd, width, ptas_n;
  logic        evt, l2h_n, int_en, flt_n, sel_n, rd_n, wr_n;
  logic        bclk, brst_n, pt_wr, irq_n, inta_n, inta_oe_n, pin_oe_n;
  logic [1:0]  region;
  logic [3:0]  lanes, oe_n;
  logic [4:0]  addr;
  logic [31:0] pt_addr, wdata, dq, pt_data;
  logic [35:0] q;
  int          fails, n_compared, cycles, pulses;

  lbrp_port DUT (.core_clk_i(clk), .rst_b_i(rst_b), .host_clk_i(hclk),
    .host_rst_n_i(hrst_n), .sw_reset_cmd_i(sw_cmd),
    .buffered_host_clock_o(bclk), .buffered_host_reset_n_o(brst_n),
    .select_n_i(sel_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .word_addr_i(addr),
    .byte_lane_enable_n_i(lanes), .bus_width_select_i(width),
    .dq_i(wdata), .dq_o(dq), .dq_oe_n_o(oe_n),
    .passthru_addr_strobe_n_i(ptas_n), .passthru_addr_i(pt_addr),
    .passthru_region_size_i(region), .passthru_data_o(pt_data),
    .passthru_data_wr_o(pt_wr), .internal_event_i(evt),
    .local_irq_n_o(irq_n), .local_to_host_int_n_i(l2h_n),
    .host_int_enable_i(int_en), .inta_n_o(inta_n),
    .inta_oe_n_o(inta_oe_n), .float_outputs_n_i(flt_n),
    .pin_oe_n_o(pin_oe_n));

  lbrp_local_model u_loc (.clk_i(clk), .rdata_i({oe_n, dq}),
    .select_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
    .lanes_o(lanes), .dq_o(wdata));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Timeout well above the roughly 230 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (pt_wr === 1'h1) pulses++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input string nm, input logic [35:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_edges

  task automatic t_rw32();
    u_loc.access(1'h1, 1'h0, 5'h3, 4'h0, 32'h0, q);
    check("reset_word", q, {4'h0, REG_RESET});
    u_loc.access(1'h1, 1'h1, 5'h3, 4'h0, 32'h11223344, q);
    u_loc.access(1'h1, 1'h1, 5'h3, 4'h5, 32'haabbccdd, q);
    u_loc.access(1'h1, 1'h0, 5'h3, 4'ha, 32'h0, q);
    check("lane_read", q & 36'hf00ff00ff, 36'ha00220044);
    u_loc.access(1'h1, 1'h0, 5'h3, 4'h0, 32'h0, q);
    check("lane_write", q, 36'h0aa22cc44);
  endtask : t_rw32

  task automatic t_nosel();
    u_loc.access(1'h0, 1'h1, 5'h3, 4'h0, 32'hdeadbeef, q);
    u_loc.access(1'h0, 1'h0, 5'h3, 4'h0, 32'h0, q);
    check("unselected_oe", q[35:32], 4'hf);
    u_loc.access(1'h1, 1'h0, 5'h3, 4'h0, 32'h0, q);
    check("unselected_wr", q, 36'h0aa22cc44);
  endtask : t_nosel

  task automatic t_half16();
    width = 1'h1;
    wait_edges(4);
    u_loc.access(1'h1, 1'h1, 5'h5, 4'h8, 32'hffff5a5a, q);
    u_loc.access(1'h1, 1'h1, 5'h5, 4'h0, 32'hffff1234, q);
    u_loc.access(1'h1, 1'h0, 5'h5, 4'h8, 32'h0, q);
    check("half_read", q, 36'hc00005a5a);
    width = 1'h0;
    wait_edges(4);
    u_loc.access(1'h1, 1'h0, 5'h5, 4'h0, 32'h0, q);
    check("half_word", q, 36'h05a5a1234);
  endtask : t_half16

  task automatic t_ptport();
    int p0;
    p0 = pulses;
    region = REGION_W16;
    u_loc.access(1'h1, 1'h1, PT_DATA_IDX, 4'h4, 32'hffff1234, q);
    check("pt_16", pt_data, 32'h00001234);
    check("pt_pulse", pulses - p0, 1);
    width = 1'h1;
    region = REGION_W32;
    u_loc.access(1'h1, 1'h1, PT_DATA_IDX, 4'h0, 32'hcafe0001, q);
    check("pt_32", pt_data, 32'hcafe0001);
  endtask : t_ptport

  task automatic t_ptas();
    pt_addr = 32'h87654321;
    ptas_n = 1'h0;
    wait_edges(6);
    check("pt_addr", {oe_n, dq}, {4'h0, pt_addr});
    ptas_n = 1'h1;
    wait_edges(6);
    check("pt_off", oe_n, 4'hf);
    width = 1'h0;
  endtask : t_ptas

  task automatic t_side();
    hclk = 1'h1;
    hrst_n = 1'h0;
    wait_edges(1);
    check("bclk_hi", bclk, 1'h1);
    check("brst_pin", brst_n, 1'h0);
    hclk = 1'h0;
    hrst_n = 1'h1;
    sw_cmd = 1'h1;
    wait_edges(1);
    check("bclk_lo", bclk, 1'h0);
    check("brst_sw", brst_n, 1'h0);
    sw_cmd = 1'h0;
    evt = 1'h1;
    wait_edges(2);
    check("brst_off", brst_n, 1'h1);
    check("irq", irq_n, 1'h0);
    evt = 1'h0;
    l2h_n = 1'h0;
    wait_edges(6);
    check("irq_off", irq_n, 1'h1);
    check("inta_off", inta_oe_n, 1'h1);
    int_en = 1'h1;
    wait_edges(6);
    check("inta_on", {inta_oe_n, inta_n}, 2'h0);
    flt_n = 1'h0;
    wait_edges(6);
    check("float", {pin_oe_n, inta_oe_n, oe_n}, 6'h3f);
    flt_n = 1'h1;
    wait_edges(6);
    check("unfloat", {pin_oe_n, inta_oe_n}, 2'h0);
    l2h_n = 1'h1;
    wait_edges(6);
    check("inta_rel", inta_oe_n, 1'h1);
  endtask : t_side

  task automatic t_reset();
    rst_b = 1'h0;
    wait_edges(2);
    check("reset_out", {pin_oe_n, inta_oe_n, irq_n, oe_n}, 7'h3f);
    check("reset_pt", {pt_wr, pt_data}, 33'h0);
    rst_b = 1'h1;
    u_loc.access(1'h1, 1'h0, 5'h3, 4'h0, 32'h0, q);
    check("reset_reg", q, {4'h0, REG_RESET});
  endtask : t_reset

  initial begin
    {hclk, sw_cmd, width, evt, int_en, rst_b} = 6'h0;
    {hrst_n, ptas_n, l2h_n, flt_n} = 4'hf;
    pt_addr = 32'h0;
    region = 2'h0;
    wait_edges(5);
    rst_b = 1'h1;
    t_rw32();
    t_nosel();
    t_half16();
    t_ptport();
    t_ptas();
    t_side();
    t_reset();
    report_and_stop();
  end
endmodule : lbrp_port_tb
